/* pkg/cspsc_pkg.sv */
// Purpose: Shared constants and types for the clock switch and power save controller
// Assumes: 16-bit control register reached over a plain strobe port
// Notes:   Source codes follow the three-bit select encoding

package cspsc_pkg;

  // Register offsets on the plain port
  localparam logic [1:0] CSPSC_OFS_CTRL   = 2'h0;
  localparam logic [1:0] CSPSC_OFS_STATUS = 2'h1;

  // Field positions in the control register
  localparam int CSPSC_CUR_LSB  = 12;
  localparam int CSPSC_NEW_LSB  = 8;
  localparam int CSPSC_LOCK_BIT = 5;
  localparam int CSPSC_FAIL_BIT = 3;
  localparam int CSPSC_SEN_BIT  = 1;
  localparam int CSPSC_REQ_BIT  = 0;

  // Byte-lane write strobes
  localparam logic [1:0] CSPSC_LANE_LOW  = 2'h1;
  localparam logic [1:0] CSPSC_LANE_HIGH = 2'h2;

  // Unlock key values
  localparam logic [7:0] CSPSC_KEY_HI_A = 8'h78;
  localparam logic [7:0] CSPSC_KEY_HI_B = 8'h9A;
  localparam logic [7:0] CSPSC_KEY_LO_A = 8'h46;
  localparam logic [7:0] CSPSC_KEY_LO_B = 8'h57;

  // Cycles of the new clock counted before the changeover
  localparam int unsigned CSPSC_SETTLE_CYCLES = 10;

  // Source select encoding
  typedef enum logic [2:0] {
    CSPSC_SRC_FAST_RC         = 3'h0,
    CSPSC_SRC_FAST_RC_PLL     = 3'h1,
    CSPSC_SRC_PRIMARY         = 3'h2,
    CSPSC_SRC_PRIMARY_PLL     = 3'h3,
    CSPSC_SRC_SECONDARY       = 3'h4,
    CSPSC_SRC_LOW_POWER_RC    = 3'h5,
    CSPSC_SRC_RESERVED        = 3'h6,
    CSPSC_SRC_FAST_RC_POSTDIV = 3'h7
  } cspsc_src_e;

  // Configuration straps bundled together
  typedef struct packed {
    logic       switch_cfg_upper_bit;
    logic       switch_cfg_lower_bit;
    cspsc_src_e powerup_source_cfg;
    logic [1:0] primary_submode_cfg;
    logic       watchdog_enable;
  } cspsc_cfg_s;

  // Oscillator enables driven to the analog side
  typedef struct packed {
    logic primary_osc;
    logic secondary_osc;
    logic fast_rc_osc;
    logic low_power_rc_osc;
    logic pll;
  } cspsc_osc_s;

  // Oscillator readiness from the analog side
  typedef struct packed {
    logic primary_startup_done;
    logic pll_locked;
    logic new_clk_tick;
  } cspsc_ready_s;

endpackage

/* hdl/cspsc_settle_cnt.sv */
// Purpose: Counts ticks of the newly selected clock before changeover
// Assumes: Ticks arrive as one-cycle enable pulses synchronous to core_clk_i
// Notes:   Done is a registered level until cleared by start

`timescale 1ns/1ps

module cspsc_settle_cnt #(
  parameter int unsigned COUNT = 10
) (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic start_i,
  input  wire logic tick_i,
  output logic      done_o
);

  localparam int W = $clog2(COUNT + 1);

  logic [W-1:0] cnt_q, cnt_d;
  logic         run_q, run_d;
  logic         done_q, done_d;

  // Start reloads; each tick counts once while running
  always_comb begin
    cnt_d  = cnt_q;
    run_d  = run_q;
    done_d = done_q;
    if (start_i) begin
      cnt_d  = '0;
      run_d  = 1'b1;
      done_d = 1'b0;
    end else if (run_q && tick_i) begin
      cnt_d = cnt_q + W'(1);
      if (cnt_q == W'(COUNT - 1)) begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      run_q  <= run_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;

endmodule

/* hdl/cspsc_top.sv */
// Purpose: Run-time system clock switching, unlock protection and sleep/idle control
// Assumes: Configuration straps steady after reset; oscillator readiness synchronous
// Notes:   Notes on behaviour below

`timescale 1ns/1ps

module cspsc_top (
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_i,
  input  wire cspsc_pkg::cspsc_cfg_s cfg_i,
  input  wire logic [1:0]            reg_addr_i,
  input  wire logic [15:0]           reg_wdata_i,
  input  wire logic [1:0]            reg_lane_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic [15:0]                reg_rdata_o,
  input  wire cspsc_pkg::cspsc_ready_s ready_i,
  input  wire logic                  clock_fail_i,
  input  wire logic                  sleep_instr_i,
  input  wire logic                  idle_instr_i,
  input  wire logic                  wake_irq_i,
  input  wire logic                  watchdog_timeout_i,
  output cspsc_pkg::cspsc_osc_s      osc_en_o,
  output cspsc_pkg::cspsc_src_e      sys_clk_sel_o,
  output logic                       sys_clk_run_o,
  output logic                       cpu_clk_run_o,
  output logic                       watchdog_clear_o,
  output logic                       failsafe_active_o,
  output logic                       switch_busy_o
);
  import cspsc_pkg::*;

  typedef enum logic [1:0] {
    CSPSC_SW_IDLE  = 2'b00,
    CSPSC_SW_WAIT  = 2'b01,
    CSPSC_SW_SETTLE = 2'b10
  } cspsc_sw_e;

  typedef enum logic [1:0] {
    CSPSC_PM_RUN   = 2'b00,
    CSPSC_PM_SLEEP = 2'b01,
    CSPSC_PM_IDLE  = 2'b10
  } cspsc_pm_e;

  typedef enum logic [1:0] {
    CSPSC_UL_NONE = 2'b00,
    CSPSC_UL_HALF = 2'b01,
    CSPSC_UL_OPEN = 2'b10
  } cspsc_ul_e;

  // True for sources that run through the PLL; codes as in the package encoding
  function automatic logic uses_pll(input cspsc_src_e s);
    return (s == CSPSC_SRC_FAST_RC_PLL) || (s == CSPSC_SRC_PRIMARY_PLL);
  endfunction

  // Oscillator enable vector needed by one source
  function automatic cspsc_osc_s osc_of(input cspsc_src_e s);
    cspsc_osc_s o;
    o = '0;
    unique case (s)
      CSPSC_SRC_PRIMARY, CSPSC_SRC_PRIMARY_PLL: o.primary_osc = 1'b1;
      CSPSC_SRC_SECONDARY:                      o.secondary_osc = 1'b1;
      CSPSC_SRC_LOW_POWER_RC:                   o.low_power_rc_osc = 1'b1;
      default:                                  o.fast_rc_osc = 1'b1;
    endcase
    o.pll = uses_pll(s);
    return o;
  endfunction

  logic switch_en;
  logic fsm_en;
  assign switch_en = ~cfg_i.switch_cfg_upper_bit;
  assign fsm_en    = ~cfg_i.switch_cfg_upper_bit & ~cfg_i.switch_cfg_lower_bit;

  cspsc_src_e cur_q, cur_d;
  cspsc_src_e new_q, new_d;
  cspsc_src_e tgt_q, tgt_d;
  logic       req_q, req_d;
  logic       lock_q, lock_d;
  logic       fail_q, fail_d;
  logic       sen_q, sen_d;
  cspsc_sw_e  sw_q, sw_d;
  cspsc_ul_e  ulh_q, ulh_d;
  cspsc_ul_e  ull_q, ull_d;
  cspsc_pm_e  pm_q, pm_d;
  logic       wdclr_q, wdclr_d;
  logic [15:0] rdata_q, rdata_d;
  logic       settle_start;
  logic       settle_done;

  logic wr_ctrl, wr_hi, wr_lo;
  assign wr_ctrl = reg_wr_i && (reg_addr_i == CSPSC_OFS_CTRL);
  assign wr_hi   = wr_ctrl && reg_lane_i[1];
  assign wr_lo   = wr_ctrl && reg_lane_i[0];

  // Unlock trackers; open lets at most one write through, and any other write closes it
  always_comb begin
    ulh_d = ulh_q;
    ull_d = ull_q;
    if (wr_hi) begin
      unique case (ulh_q)
        CSPSC_UL_NONE: ulh_d = (reg_wdata_i[15:8] == CSPSC_KEY_HI_A) ? CSPSC_UL_HALF : CSPSC_UL_NONE;
        CSPSC_UL_HALF: ulh_d = (reg_wdata_i[15:8] == CSPSC_KEY_HI_B) ? CSPSC_UL_OPEN :
                               ((reg_wdata_i[15:8] == CSPSC_KEY_HI_A) ? CSPSC_UL_HALF : CSPSC_UL_NONE);
        default:       ulh_d = CSPSC_UL_NONE;
      endcase
    end else if (reg_wr_i) begin
      ulh_d = CSPSC_UL_NONE;
    end
    if (wr_lo) begin
      unique case (ull_q)
        CSPSC_UL_NONE: ull_d = (reg_wdata_i[7:0] == CSPSC_KEY_LO_A) ? CSPSC_UL_HALF : CSPSC_UL_NONE;
        CSPSC_UL_HALF: ull_d = (reg_wdata_i[7:0] == CSPSC_KEY_LO_B) ? CSPSC_UL_OPEN :
                               ((reg_wdata_i[7:0] == CSPSC_KEY_LO_A) ? CSPSC_UL_HALF : CSPSC_UL_NONE);
        default:       ull_d = CSPSC_UL_NONE;
      endcase
    end else if (reg_wr_i) begin
      ull_d = CSPSC_UL_NONE;
    end
  end

  logic hi_commit, lo_commit;
  assign hi_commit = wr_hi && (ulh_q == CSPSC_UL_OPEN);
  assign lo_commit = wr_lo && (ull_q == CSPSC_UL_OPEN);

  // Register fields and switch sequencer; processor never waits on it
  always_comb begin
    cur_d = cur_q;
    new_d = new_q;
    tgt_d = tgt_q;
    req_d = req_q;
    lock_d = lock_q;
    fail_d = fail_q;
    sen_d = sen_q;
    sw_d  = sw_q;
    settle_start = 1'b0;
    if (hi_commit && switch_en) begin
      new_d = cspsc_src_e'(reg_wdata_i[CSPSC_NEW_LSB +: 3]);
    end
    if (lo_commit) begin
      sen_d = reg_wdata_i[CSPSC_SEN_BIT];
      if (switch_en && reg_wdata_i[CSPSC_REQ_BIT]) begin
        req_d = 1'b1;
      end
      if (!reg_wdata_i[CSPSC_FAIL_BIT]) begin
        fail_d = 1'b0;                                                              // Clear-only flag
      end
    end
    if (clock_fail_i && fsm_en && pm_q != CSPSC_PM_SLEEP) begin
      fail_d = 1'b1;                                                                // Set wins over clear
    end
    if (uses_pll(cur_q) && sw_q == CSPSC_SW_IDLE) begin
      lock_d = ready_i.pll_locked;
    end else if (sw_q == CSPSC_SW_IDLE) begin
      lock_d = 1'b0;
    end
    unique case (sw_q)
      CSPSC_SW_IDLE: begin
        if (req_q && switch_en) begin
          if (new_q == cur_q) begin
            req_d = 1'b0;
          end else begin
            lock_d = 1'b0;
            fail_d = clock_fail_i && fsm_en;
            tgt_d  = new_q;
            sw_d   = CSPSC_SW_WAIT;
          end
        end
      end
      CSPSC_SW_WAIT: begin
        if ((!(tgt_q inside {CSPSC_SRC_PRIMARY, CSPSC_SRC_PRIMARY_PLL}) || ready_i.primary_startup_done) &&
            (!uses_pll(tgt_q) || ready_i.pll_locked)) begin
          lock_d = uses_pll(tgt_q);
          settle_start = 1'b1;
          sw_d = CSPSC_SW_SETTLE;
        end
      end
      CSPSC_SW_SETTLE: begin
        if (settle_done) begin
          cur_d = tgt_q;
          req_d = 1'b0;
          sw_d  = CSPSC_SW_IDLE;
        end
      end
      default: sw_d = CSPSC_SW_IDLE;
    endcase
    if (!switch_en) begin
      req_d = 1'b0;
      cur_d = cfg_i.powerup_source_cfg;
      sw_d  = CSPSC_SW_IDLE;
    end
  end

  cspsc_settle_cnt #(
    .COUNT (CSPSC_SETTLE_CYCLES)
  ) u_settle (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .start_i    (settle_start),
    .tick_i     (ready_i.new_clk_tick),
    .done_o     (settle_done)
  );

  // Power-save mode; wake checked from the first cycle after entry
  always_comb begin
    pm_d    = pm_q;
    wdclr_d = 1'b0;
    unique case (pm_q)
      CSPSC_PM_RUN: begin
        if (sleep_instr_i) begin
          pm_d    = CSPSC_PM_SLEEP;
          wdclr_d = cfg_i.watchdog_enable;
        end else if (idle_instr_i) begin
          pm_d    = CSPSC_PM_IDLE;
          wdclr_d = cfg_i.watchdog_enable;
        end
      end
      default: begin
        if (wake_irq_i || watchdog_timeout_i) begin
          pm_d = CSPSC_PM_RUN;
        end
      end
    endcase
  end

  // Read port, data in the cycle after the strobe
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        CSPSC_OFS_CTRL: begin
          rdata_d[CSPSC_CUR_LSB +: 3] = cur_q;
          rdata_d[CSPSC_NEW_LSB +: 3] = new_q;
          rdata_d[CSPSC_LOCK_BIT]     = lock_q;
          rdata_d[CSPSC_FAIL_BIT]     = fail_q;
          rdata_d[CSPSC_SEN_BIT]      = sen_q;
          rdata_d[CSPSC_REQ_BIT]      = req_q;
        end
        CSPSC_OFS_STATUS: rdata_d = {12'h000, fsm_en, switch_en, pm_q};
        default:          rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cur_q   <= CSPSC_SRC_FAST_RC_POSTDIV;
      new_q   <= CSPSC_SRC_FAST_RC_POSTDIV;
      tgt_q   <= CSPSC_SRC_FAST_RC_POSTDIV;
      req_q   <= 1'b0;
      lock_q  <= 1'b0;
      fail_q  <= 1'b0;
      sen_q   <= 1'b0;
      sw_q    <= CSPSC_SW_IDLE;
      ulh_q   <= CSPSC_UL_NONE;
      ull_q   <= CSPSC_UL_NONE;
      pm_q    <= CSPSC_PM_RUN;
      wdclr_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      cur_q   <= cur_d;
      new_q   <= new_d;
      tgt_q   <= tgt_d;
      req_q   <= req_d;
      lock_q  <= lock_d;
      fail_q  <= fail_d;
      sen_q   <= sen_d;
      sw_q    <= sw_d;
      ulh_q   <= ulh_d;
      ull_q   <= ull_d;
      pm_q    <= pm_d;
      wdclr_q <= wdclr_d;
      rdata_q <= rdata_d;
    end
  end

  // Oscillator enables; old source drops when current changes
  cspsc_osc_s need;
  always_comb begin
    need = osc_of(cur_q);
    if (sw_q != CSPSC_SW_IDLE) begin
      need = need | osc_of(tgt_q);
    end
    if (pm_q == CSPSC_PM_SLEEP) begin
      need = '0;
    end
    need.secondary_osc    = need.secondary_osc | sen_q;
    need.low_power_rc_osc = need.low_power_rc_osc | cfg_i.watchdog_enable |
                            (fsm_en && pm_q != CSPSC_PM_SLEEP);
  end

  assign osc_en_o          = need;
  assign reg_rdata_o       = rdata_q;
  assign sys_clk_sel_o     = cur_q;
  assign sys_clk_run_o     = (pm_q != CSPSC_PM_SLEEP);
  assign cpu_clk_run_o     = (pm_q == CSPSC_PM_RUN);
  assign watchdog_clear_o  = wdclr_q;
  assign failsafe_active_o = fsm_en && (pm_q != CSPSC_PM_SLEEP);
  assign switch_busy_o     = (sw_q != CSPSC_SW_IDLE);

  chk_redundant_abort: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (sw_q == CSPSC_SW_IDLE && req_q && switch_en && new_q == cur_q) |=> !req_q)
    else $error("redundant switch not abandoned");
  chk_start_clears: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (sw_q == CSPSC_SW_IDLE && $past(sw_q) == CSPSC_SW_IDLE && sw_d == CSPSC_SW_WAIT) |=> !lock_q)
    else $error("lock not cleared at switch start");
  chk_req_held_zero: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !switch_en |=> !req_q)
    else $error("request bit set while switching disabled");
  chk_cur_follows_cfg: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !switch_en |=> cur_q == $past(cfg_i.powerup_source_cfg))
    else $error("current field not tracking power-up source");
  chk_commit_copies: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (sw_q == CSPSC_SW_SETTLE && settle_done && switch_en) |=> (cur_q == $past(tgt_q)) && !req_q)
    else $error("changeover did not copy source");
  chk_no_lock_write: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (wr_hi && ulh_q != CSPSC_UL_OPEN && sw_q == CSPSC_SW_IDLE && switch_en) |=> new_q == $past(new_q))
    else $error("locked high byte write took effect");
  chk_sleep_quiet: assert property (@(posedge core_clk_i) disable iff (reset_i)
    pm_q == CSPSC_PM_SLEEP |-> !failsafe_active_o && !sys_clk_run_o && !osc_en_o.fast_rc_osc)
    else $error("clock or monitor active in sleep");
  chk_wake_run: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (pm_q != CSPSC_PM_RUN && wake_irq_i) |=> pm_q == CSPSC_PM_RUN && cpu_clk_run_o)
    else $error("no wake on interrupt");
  chk_sleep_wdclr: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (pm_q == CSPSC_PM_RUN && sleep_instr_i && cfg_i.watchdog_enable) |=> watchdog_clear_o)
    else $error("watchdog not cleared on sleep entry");

  cov_switch_done: cover property (@(posedge core_clk_i) sw_q == CSPSC_SW_SETTLE && settle_done);
  cov_redundant: cover property (@(posedge core_clk_i) sw_q == CSPSC_SW_IDLE && req_q && new_q == cur_q);
  cov_sleep_wake: cover property (@(posedge core_clk_i) pm_q == CSPSC_PM_SLEEP ##1 pm_q == CSPSC_PM_RUN);
  cov_idle: cover property (@(posedge core_clk_i) pm_q == CSPSC_PM_IDLE);

endmodule

/* verif/cspsc_osc_model.sv */
// Purpose: Behavioural oscillator and PLL side facing the clock switch controller
// Assumes: Enables from the controller are synchronous to core_clk_i
// Notes:   Delays are short parameters so that a run stays brief
`timescale 1ns/1ps
module cspsc_osc_model
  import cspsc_pkg::*;
#(
  parameter int unsigned STARTUP = 20,
  parameter int unsigned LOCKUP  = 15,
  parameter int unsigned TICKDIV = 3
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_i,
  input  wire cspsc_pkg::cspsc_osc_s osc_en_i,
  output cspsc_pkg::cspsc_ready_s    ready_o
);
  int unsigned up_cnt;
  int unsigned lock_cnt;
  int unsigned tick_cnt;
  // Dropping an enable restarts its wait, so a stale ready never leaks through
  always @(posedge core_clk_i) begin
    up_cnt   <= (reset_i || !osc_en_i.primary_osc) ? 0 : (up_cnt < STARTUP) ? up_cnt + 1 : up_cnt;
    lock_cnt <= (reset_i || !osc_en_i.pll) ? 0 : (lock_cnt < LOCKUP) ? lock_cnt + 1 : lock_cnt;
    tick_cnt <= (reset_i || tick_cnt == TICKDIV - 1) ? 0 : tick_cnt + 1;
  end
  // Ready levels and the new-clock tick pulse
  assign ready_o = '{primary_startup_done: (up_cnt == STARTUP),
                     pll_locked:           (lock_cnt == LOCKUP),
                     new_clk_tick:         (tick_cnt == TICKDIV - 1) && !reset_i};
endmodule

/* verif/cspsc_top_tb_top.sv */
// Purpose: Self-checking bench for the clock switch and power save controller
// Assumes: Oscillator side modelled with short start-up and lock delays
// Notes:   Strobes change right after rising edges; outputs sampled 1 ns later
`timescale 1ns/1ps
module cspsc_top_tb_top;
  import cspsc_pkg::*;
  logic         core_clk;
  logic         rst;
  cspsc_cfg_s   cfg;
  logic [1:0]   reg_addr;
  logic [15:0]  reg_wdata;
  logic [1:0]   reg_lane;
  logic         reg_wr;
  logic         reg_rd;
  logic [15:0]  rdata;
  cspsc_ready_s ready;
  logic         clk_fail;
  logic         sleep;
  logic         idle;
  logic         wake;
  logic         wdt_to;
  cspsc_osc_s   osc_en;
  cspsc_src_e   sel;
  logic         sys_run;
  logic         cpu_run;
  logic         wd_clr;
  logic         fs_act;
  logic         busy;
  int           miscompares;
  int           checked;
  int           cycles;
  int           n;
  logic [15:0]  d;
  cspsc_src_e   order [7] = '{CSPSC_SRC_PRIMARY, CSPSC_SRC_PRIMARY_PLL, CSPSC_SRC_FAST_RC, CSPSC_SRC_FAST_RC_PLL,
                              CSPSC_SRC_LOW_POWER_RC, CSPSC_SRC_SECONDARY, CSPSC_SRC_FAST_RC_POSTDIV};

  cspsc_top uut (
    .core_clk_i(core_clk), .reset_i(rst), .cfg_i(cfg), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_lane_i(reg_lane), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .ready_i(ready),
    .clock_fail_i(clk_fail), .sleep_instr_i(sleep), .idle_instr_i(idle), .wake_irq_i(wake),
    .watchdog_timeout_i(wdt_to), .osc_en_o(osc_en), .sys_clk_sel_o(sel), .sys_clk_run_o(sys_run),
    .cpu_clk_run_o(cpu_run), .watchdog_clear_o(wd_clr), .failsafe_active_o(fs_act), .switch_busy_o(busy)
  );
  cspsc_osc_model partner (.core_clk_i(core_clk), .reset_i(rst), .osc_en_i(osc_en), .ready_o(ready));

  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic end_sim();
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Control writes; back-to-back calls keep the strobe high
  task automatic wr(input logic [1:0] lane, input logic [15:0] data);
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    reg_addr  <= CSPSC_OFS_CTRL;
    reg_lane  <= lane;
    reg_wdata <= data;
    @(posedge core_clk);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] addr);
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= addr;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic settle();
    reg_wr <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic wait_busy(input logic lvl, input int lim);
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask

  task automatic do_reset(input cspsc_cfg_s c);
    cfg <= c;
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic request(input cspsc_src_e src);
    wr(CSPSC_LANE_HIGH, {CSPSC_KEY_HI_A, 8'h00});
    wr(CSPSC_LANE_HIGH, {CSPSC_KEY_HI_B, 8'h00});
    wr(CSPSC_LANE_HIGH, {5'h00, src, 8'h00});
    wr(CSPSC_LANE_LOW, {8'h00, CSPSC_KEY_LO_A});
    wr(CSPSC_LANE_LOW, {8'h00, CSPSC_KEY_LO_B});
    wr(CSPSC_LANE_LOW, 16'h0001);
    settle();
  endtask

  // Switching strapped off: select and request must do nothing
  task automatic t_disabled();
    do_reset({1'b1, 1'b1, CSPSC_SRC_PRIMARY, 2'h1, 1'b1});
    request(CSPSC_SRC_LOW_POWER_RC);
    wait_busy(1'b1, 10);
    rd(CSPSC_OFS_CTRL);
    cmp({13'h0, d[14:12]}, 16'h2);
    cmp({15'h0, d[0]}, 16'h0);
    cmp({13'h0, sel}, 16'h2);
    cmp({14'h0, busy, fs_act}, 16'h0);
    rd(CSPSC_OFS_STATUS);
    cmp(d, 16'h0);
  endtask

  // Broken and reused unlock pairs, a redundant request and a clock failure
  task automatic t_unlock();
    do_reset({1'b0, 1'b0, CSPSC_SRC_FAST_RC_POSTDIV, 2'h1, 1'b1});
    rd(CSPSC_OFS_CTRL);
    cmp(d, 16'h7700);
    rd(CSPSC_OFS_STATUS);
    cmp(d, 16'h000C);
    rd(2'h3);
    cmp(d, 16'h0000);
    wr(CSPSC_LANE_HIGH, {CSPSC_KEY_HI_A, 8'h00});
    wr(CSPSC_LANE_LOW, 16'h0000);
    wr(CSPSC_LANE_HIGH, {CSPSC_KEY_HI_B, 8'h00});
    wr(CSPSC_LANE_HIGH, 16'h0200);
    wr(CSPSC_LANE_HIGH, {CSPSC_KEY_HI_A, 8'h00});
    wr(CSPSC_LANE_HIGH, 16'h9B00);
    wr(CSPSC_LANE_HIGH, 16'h0200);
    rd(CSPSC_OFS_CTRL);
    cmp({13'h0, d[10:8]}, 16'h7);
    wr(CSPSC_LANE_LOW, {8'h00, CSPSC_KEY_LO_A});
    wr(CSPSC_LANE_LOW, {8'h00, CSPSC_KEY_LO_B});
    wr(CSPSC_LANE_LOW, 16'h0001);
    settle();
    wait_busy(1'b1, 10);
    rd(CSPSC_OFS_CTRL);
    cmp({14'h0, busy, d[0]}, 16'h0);
    wr(CSPSC_LANE_HIGH, {CSPSC_KEY_HI_A, 8'h00});
    wr(CSPSC_LANE_HIGH, {CSPSC_KEY_HI_B, 8'h00});
    wr(CSPSC_LANE_HIGH, 16'h0200);
    wr(CSPSC_LANE_HIGH, 16'h0300);
    settle();
    rd(CSPSC_OFS_CTRL);
    cmp({13'h0, d[10:8]}, 16'h2);
    clk_fail <= 1'b1;
    @(posedge core_clk);
    clk_fail <= 1'b0;
    rd(CSPSC_OFS_CTRL);
    cmp({15'h0, d[3]}, 16'h1);
  endtask

  // One full switch with its status changes along the way
  task automatic t_switch(input cspsc_src_e src);
    logic [4:0] want;
    request(src);
    wait_busy(1'b1, 10);
    cmp({14'h0, busy, cpu_run}, 16'h3);
    rd(CSPSC_OFS_CTRL);
    cmp({14'h0, d[5], d[3]}, 16'h0);
    wait_busy(1'b0, 400);
    cmp({15'h0, n >= 25}, 16'h1);
    rd(CSPSC_OFS_CTRL);
    cmp({d[15:8], 7'h0, d[0]}, {1'b0, src, 1'b0, src, 8'h00});
    cmp({13'h0, sel}, {13'h0, src});
    // Only the new source stays on; low-power RC is held by the strapped watchdog
    want = {src inside {CSPSC_SRC_PRIMARY, CSPSC_SRC_PRIMARY_PLL}, src == CSPSC_SRC_SECONDARY,
            src inside {CSPSC_SRC_FAST_RC, CSPSC_SRC_FAST_RC_PLL, CSPSC_SRC_FAST_RC_POSTDIV}, 1'b1,
            src inside {CSPSC_SRC_FAST_RC_PLL, CSPSC_SRC_PRIMARY_PLL}};
    cmp({11'h0, osc_en}, {11'h0, want});
  endtask

  // Secondary enable keeps that oscillator running whatever the source
  task automatic t_secondary();
    wr(CSPSC_LANE_LOW, {8'h00, CSPSC_KEY_LO_A});
    wr(CSPSC_LANE_LOW, {8'h00, CSPSC_KEY_LO_B});
    wr(CSPSC_LANE_LOW, 16'h0002);
    rd(CSPSC_OFS_CTRL);
    cmp({14'h0, d[1], osc_en.secondary_osc}, 16'h3);
  endtask

  // Sleep entry, then wake by interrupt and by watchdog time-out
  task automatic t_sleep();
    sleep <= 1'b1;
    @(posedge core_clk);
    sleep <= 1'b0;
    #1 cmp({12'h0, sys_run, cpu_run, wd_clr, fs_act}, 16'h2);
    cmp({14'h0, osc_en.fast_rc_osc, osc_en.low_power_rc_osc}, 16'h1);
    wake <= 1'b1;
    @(posedge core_clk);
    wake <= 1'b0;
    #1 cmp({14'h0, cpu_run, sys_run}, 16'h3);
    cmp({13'h0, sel}, 16'h7);
    sleep <= 1'b1;
    @(posedge core_clk);
    sleep <= 1'b0;
    wdt_to <= 1'b1;
    @(posedge core_clk);
    wdt_to <= 1'b0;
    #1 cmp({15'h0, cpu_run}, 16'h1);
  endtask

  // Idle with an interrupt coincident with the instruction
  task automatic t_idle();
    idle <= 1'b1;
    wake <= 1'b1;
    @(posedge core_clk);
    idle <= 1'b0;
    #1 cmp({13'h0, sys_run, cpu_run, wd_clr}, 16'h5);
    @(posedge core_clk);
    wake <= 1'b0;
    #1 cmp({15'h0, cpu_run}, 16'h1);
  endtask

  // Main sequence
  initial begin
    miscompares = 0;
    checked = 0;
    cycles = 0;
    {reg_addr, reg_wdata, reg_lane, reg_wr, reg_rd} = '0;
    {clk_fail, sleep, idle, wake, wdt_to} = '0;
    t_disabled();
    t_unlock();
    foreach (order[i]) t_switch(order[i]);
    t_secondary();
    t_sleep();
    t_idle();
    end_sim();
  end
endmodule
